// *** rtl/parallel_to_serial_8to1.sv ***
// Purpose: 8:1 parallel to serial converter with word framing clock, rate select,
//   restart and clock suspend
// Assumes: All inputs synchronous to ref_clk; ref_clk edges alternate as rising and
//   falling edges of the converter clock
// Notes: Restart acts at the next ref_clk edge, the closest a synchronous design gets
`timescale 1ns/1ps
module parallel_to_serial_8to1 (
  input wire logic ref_clk, // 50 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic restart, // Restart, active high
  input wire logic rate_select, // 1: two bits per clock cycle
  input wire logic clock_suspend, // 1: freeze activity
  input wire ser_pkg::word_t parallel_in, // Parallel word from upstream
  output ser_pkg::ser_out_s ser_o // Serial bit and framing clock
);
  logic phase_ff; // 1: coming edge is a falling edge
  logic frozen_ff;
  logic [3:0] pos_ff;
  ser_pkg::word_t hold_ff [ser_pkg::HOLD_DEPTH];
  logic [ser_pkg::WORD_W-2:0] shift_ff;
  ser_pkg::ser_out_s ser_ff;

  logic nxt_phase;
  logic nxt_frozen;
  logic [3:0] nxt_pos;
  ser_pkg::word_t nxt_hold [ser_pkg::HOLD_DEPTH];
  logic [ser_pkg::WORD_W-2:0] nxt_shift;
  ser_pkg::ser_out_s nxt_ser;

  logic clr;
  logic run;
  logic [3:0] pos_max;
  logic [3:0] pos_inc;
  logic tick_fall;
  logic latch_now;
  logic slot;
  logic load_now;
  logic [1:0] load_stage;
  logic frame_tog;

  // Tick decode: which edge comes next and what happens on it
  always_comb begin
    clr = rst | restart;
    run = ~clr & ~frozen_ff;
    pos_max = rate_select ? ser_pkg::HIGH_POS_MAX : ser_pkg::LOW_POS_MAX;
    pos_inc = (pos_ff + 4'h1) & pos_max;
    tick_fall = pos_inc[0];
    latch_now = run & (pos_inc == ser_pkg::LATCH_POS);
    slot = run & (rate_select | tick_fall);
    load_now = slot & (pos_inc == (rate_select ? ser_pkg::HIGH_LOAD_POS
                                               : ser_pkg::LOW_LOAD_POS));
    load_stage = rate_select ? ser_pkg::HIGH_LOAD_STAGE : ser_pkg::LOW_LOAD_STAGE;
    if (rate_select) begin
      frame_tog = run & ((pos_inc == ser_pkg::HIGH_FRAME_A) |
                         (pos_inc == ser_pkg::HIGH_FRAME_B));
    end else begin
      frame_tog = run & ((pos_inc == ser_pkg::LOW_FRAME_A) |
                         (pos_inc == ser_pkg::LOW_FRAME_B));
    end
  end

  // Phase, suspend and frame position
  always_comb begin
    nxt_phase = clr ? ser_pkg::PHASE_RST : ~phase_ff;
    nxt_frozen = frozen_ff;
    if (clr) begin
      nxt_frozen = ser_pkg::FROZEN_RST;
    end else if (phase_ff) begin
      nxt_frozen = clock_suspend;
    end
    if (clr) begin
      // Release is taken on the clock so the first bit is full width
      nxt_pos = rate_select ? ser_pkg::HIGH_RESTART_POS
                            : ser_pkg::LOW_RESTART_POS;
    end else if (run) begin
      nxt_pos = pos_inc;
    end else begin
      nxt_pos = pos_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    phase_ff <= nxt_phase;
    frozen_ff <= nxt_frozen;
    pos_ff <= nxt_pos;
  end

  // Word hold pipeline, shifter and output selection
  always_comb begin
    for (int i = 0; i < ser_pkg::HOLD_DEPTH; i++) begin
      nxt_hold[i] = hold_ff[i];
    end
    nxt_shift = shift_ff;
    nxt_ser = ser_ff;
    if (clr) begin
      for (int i = 0; i < ser_pkg::HOLD_DEPTH; i++) begin
        nxt_hold[i] = '0;
      end
      nxt_shift = '0;
      nxt_ser = '0;
    end else begin
      if (latch_now) begin
        for (int i = ser_pkg::HOLD_DEPTH - 1; i > 0; i--) begin
          nxt_hold[i] = hold_ff[i-1];
        end
        nxt_hold[0] = parallel_in;
      end
      if (load_now) begin
        nxt_ser.serial_out = hold_ff[load_stage][0];
        nxt_shift = hold_ff[load_stage][ser_pkg::WORD_W-1:1];
      end else if (slot) begin
        nxt_ser.serial_out = shift_ff[0];
        nxt_shift = {1'b0, shift_ff[ser_pkg::WORD_W-2:1]};
      end
      if (frame_tog) begin
        nxt_ser.frame_clk = ~ser_ff.frame_clk;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    hold_ff <= nxt_hold;
    shift_ff <= nxt_shift;
    ser_ff <= nxt_ser;
  end

  assign ser_o = ser_ff;

  // Checking helpers: count cycles of steady running
  logic [5:0] quiet_ff;
  logic [5:0] nxt_quiet;
  logic rate_q_ff;
  logic nxt_rate_q;

  always_comb begin
    nxt_rate_q = rst ? 1'b0 : rate_select;
    nxt_quiet = quiet_ff;
    if (rst | restart | frozen_ff | (rate_select != rate_q_ff)) begin
      nxt_quiet = '0;
    end else if (quiet_ff != 6'h3f) begin
      nxt_quiet = quiet_ff + 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    quiet_ff <= nxt_quiet;
    rate_q_ff <= nxt_rate_q;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_release_low;
    restart ##1 (!restart && !rate_select && !clock_suspend);
  endsequence

  sequence s_release_high;
    restart ##1 (!restart && rate_select && !clock_suspend) [*3];
  endsequence

  property p_first_bit_low;
    (quiet_ff > 6'h14) && !rate_select && $past(latch_now, 16)
      |-> ser_ff.serial_out == $past(parallel_in[0], 16);
  endproperty
  a_first_bit_low: assert property (p_first_bit_low)
    else $error("first serial bit wrong or late with rate low");

  property p_first_bit_high;
    (quiet_ff > 6'h20) && rate_select && $past(latch_now, 29)
      |-> ser_ff.serial_out == $past(parallel_in[0], 29);
  endproperty
  a_first_bit_high: assert property (p_first_bit_high)
    else $error("first serial bit wrong or late with rate high");

  property p_bit_order;
    (quiet_ff > 6'h22) && rate_select && $past(latch_now, 30)
      |-> ser_ff.serial_out == $past(parallel_in[1], 30) ##1
          ser_ff.serial_out == $past(parallel_in[2], 31);
  endproperty
  a_bit_order: assert property (p_bit_order)
    else $error("serial bits out of order");

  property p_frame_fall;
    $changed(ser_ff.frame_clk) && !$past(restart) && !$past(rate_select)
      |-> $past(phase_ff);
  endproperty
  a_frame_fall: assert property (p_frame_fall)
    else $error("framing clock moved on a rising edge with rate low");

  property p_frame_rise;
    $changed(ser_ff.frame_clk) && !$past(restart) && $past(rate_select)
      |-> !$past(phase_ff);
  endproperty
  a_frame_rise: assert property (p_frame_rise)
    else $error("framing clock moved on a falling edge with rate high");

  property p_frame_period;
    (quiet_ff > 6'h14) && !rate_select && $changed(ser_ff.frame_clk)
      |-> $past(ser_ff.frame_clk, 8) != $past(ser_ff.frame_clk, 9);
  endproperty
  a_frame_period: assert property (p_frame_period)
    else $error("framing clock period wrong with rate low");

  property p_restart_clears;
    restart |=> (ser_ff == '0) && !frozen_ff && (shift_ff == '0);
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("restart did not clear state");

  property p_release_low;
    s_release_low ##1 (!restart && !rate_select) |-> latch_now;
  endproperty
  a_release_low: assert property (p_release_low)
    else $error("first latch not on next rising edge after release");

  property p_release_high;
    s_release_high ##1 (!restart && rate_select) |-> latch_now;
  endproperty
  a_release_high: assert property (p_release_high)
    else $error("first latch not on second rising edge after release");

  property p_freeze;
    frozen_ff && !restart |=> $stable(ser_ff) && $stable(pos_ff);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("activity while suspended");

  property p_resume;
    phase_ff && frozen_ff && !clock_suspend && !restart |=> !frozen_ff;
  endproperty
  a_resume: assert property (p_resume)
    else $error("no resume after suspend dropped");

  property p_suspend_edge;
    $changed(frozen_ff) && !$past(restart) |-> $past(phase_ff);
  endproperty
  a_suspend_edge: assert property (p_suspend_edge)
    else $error("suspend changed away from a falling edge");
endmodule // parallel_to_serial_8to1

// *** rtl/ser_pkg.sv ***
// Purpose: Shared constants and types for the 8:1 parallel to serial converter
// Assumes: One ref_clk edge stands for one edge of the converter clock, rising and falling
//   edges alternating, so one converter clock cycle is two ref_clk cycles
// Notes: Tick positions count ref_clk edges inside one word frame
// What this block does
// - Each latched 8-bit word leaves one bit at a time on the serial output.
// - Rate select picks serial rate of one or two bits per clock cycle.
// - Rate low: a latched word's first bit appears on falling edge of cycle 7.
// - Rate low: framing clock changes only on falling clock edges.
// - Rate high: a latched word's first bit appears on rising edge of cycle 14.
// - Rate high: framing clock changes only on rising clock edges.
// - Restart clears hold, shift, output and suspend flip-flops and presets clock phase and frame position.
// - Restart release is synchronous, so no shortened serial bit appears.
// - Rate low: after release and a falling edge, next rising edge latches.
// - Rate high: after release and a falling edge, second rising edge latches.
// - Suspend raised, then a falling edge, freezes all activity.
// - Suspend dropped, then a falling edge, resumes from the frozen state.
// - Suspend is sampled synchronously, so no runt pulse reaches any output.
// - A framing clock output marks word boundaries in the serial stream.
package ser_pkg;
  localparam int WORD_W = 8;
  localparam int HOLD_DEPTH = 4;
  // Ticks per word frame: 8 bits at one bit per clock cycle or two per cycle
  localparam logic [3:0] LOW_POS_MAX = 4'hf;
  localparam logic [3:0] HIGH_POS_MAX = 4'h7;
  localparam int LOW_FRAME_TICKS = 16;
  localparam int HIGH_FRAME_TICKS = 8;
  // Clock cycles from latch to first serial bit
  localparam int LOW_FIRST_CYC = 7;
  localparam int HIGH_FIRST_CYC = 14;
  // Same latency in ticks: falling edge of cycle 7, rising edge of cycle 14
  localparam int LOW_DELAY = 2 * LOW_FIRST_CYC + 1;
  localparam int HIGH_DELAY = 2 * HIGH_FIRST_CYC;
  localparam logic [3:0] LOW_LOAD_POS = 4'(LOW_DELAY % LOW_FRAME_TICKS);
  localparam logic [1:0] LOW_LOAD_STAGE = 2'(LOW_DELAY / LOW_FRAME_TICKS);
  localparam logic [3:0] HIGH_LOAD_POS = 4'(HIGH_DELAY % HIGH_FRAME_TICKS);
  localparam logic [1:0] HIGH_LOAD_STAGE = 2'(HIGH_DELAY / HIGH_FRAME_TICKS);
  // Framing clock toggle positions
  localparam logic [3:0] LOW_FRAME_A = 4'h7;
  localparam logic [3:0] LOW_FRAME_B = 4'hf;
  localparam logic [3:0] HIGH_FRAME_A = 4'h0;
  localparam logic [3:0] HIGH_FRAME_B = 4'h4;
  // Position held in restart so the latch lands on the first or second rising edge
  localparam logic [3:0] LOW_RESTART_POS = 4'he;
  localparam logic [3:0] HIGH_RESTART_POS = 4'h4;
  localparam logic [3:0] LATCH_POS = 4'h0;
  // Reset values
  localparam logic PHASE_RST = 1'b1;
  localparam logic FROZEN_RST = 1'b0;

  typedef logic [WORD_W-1:0] word_t;

  typedef struct packed {
    logic frame_clk;
    logic serial_out;
  } ser_out_s;
endpackage

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the 8:1 parallel to serial converter
// Assumes: Edge 0 is the last edge with restart high; odd edges after it act as falling edges
// Notes: Every edge is checked against a predicted frame clock and serial bit
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic restart = 1'b0;
  logic rate_select = 1'b0;
  logic clock_suspend = 1'b0;
  ser_pkg::word_t parallel_in;
  ser_pkg::ser_out_s ser_o;
  int err_count = 0;
  int comparisons = 0;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  parallel_to_serial_8to1 dut_u (
    .ref_clk(ref_clk),
    .rst(rst),
    .restart(restart),
    .rate_select(rate_select),
    .clock_suspend(clock_suspend),
    .parallel_in(parallel_in),
    .ser_o(ser_o)
  );

  upstream_model src_u (
    .ref_clk(ref_clk),
    .clear(rst | restart),
    .rate_select(rate_select),
    .frame_clk(ser_o.frame_clk),
    .parallel_in(parallel_in)
  );

  // Word k offered by the upstream model
  function automatic ser_pkg::word_t pat(input int k);
    return ser_pkg::word_t'(k * 8'h3b + 8'ha5);
  endfunction

  // Count a comparison and report a mismatch
  task automatic check(input logic seen, input logic exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // Print the counts and the verdict, then end the run
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Restart at the given rate, optionally suspend, and check every edge
  task automatic stream(input logic rate, input int edges, input int sus_at, input int sus_len);
    int bp, first, ftog, fper, f, v, off;
    logic fexp, bexp;
    ser_pkg::word_t w;
    bp = rate ? 1 : 2;
    // Latch at edge 2 or 4, first bit at falling edge of cycle 7 or rising edge of cycle 14
    first = rate ? 2 * 14 + 4 : 2 * 7 + 1 + 2;
    // Framing clock first toggles at frame position 15 (edge 1) or 0 (edge 4)
    ftog = rate ? 4 : 1;
    fper = rate ? 4 : 8;
    f = sus_at + 1;
    @(posedge ref_clk);
    restart <= 1'b1;
    rate_select <= rate;
    @(posedge ref_clk);
    restart <= 1'b0;
    for (int e = 0; e <= edges; e++) begin
      if (e > 0) begin
        @(posedge ref_clk);
      end
      if (sus_len > 0 && e == sus_at) begin
        clock_suspend <= 1'b1;
      end
      if (sus_len > 0 && e == sus_at + sus_len) begin
        clock_suspend <= 1'b0;
      end
      // Frozen edges do not advance the converter
      v = (e <= f) ? e : e - ((e - f < sus_len) ? e - f : sus_len);
      #1;
      fexp = (v >= ftog) ? 1'(((v - ftog) / fper + 1) % 2) : 1'b0;
      off = v - first;
      w = (off >= 0) ? pat(off / (8 * bp)) : 8'h00;
      bexp = (off >= 0) ? w[(off % (8 * bp)) / bp] : 1'b0;
      check(ser_o.frame_clk, fexp, "framing clock");
      check(ser_o.serial_out, bexp, "serial bit");
    end
  endtask

  // Rate low: four whole words after a restart
  task automatic t_rate_low();
    stream(1'b0, 82, 0, 0);
  endtask

  // Rate high: five whole words after a restart
  task automatic t_rate_high();
    stream(1'b1, 72, 0, 0);
  endtask

  // Restart in mid-word at both rates
  task automatic t_restart_mid();
    stream(1'b0, 41, 0, 0);
    stream(1'b0, 60, 0, 0);
    stream(1'b1, 37, 0, 0);
    stream(1'b1, 50, 0, 0);
  endtask

  // Suspend across a framing toggle and inside a word, then resume
  task automatic t_suspend();
    stream(1'b1, 70, 34, 6);
    stream(1'b0, 80, 20, 10);
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_rate_low();
    t_rate_high();
    t_restart_mid();
    t_suspend();
    stop_test();
  end
endmodule // tb_top

// *** tb/upstream_model.sv ***
// Purpose: Upstream source that offers the next word, paced by the framing clock
// Assumes: The framing clock reaches the rate's level at least one edge clear of the next latch
// Notes: Word k is a fixed pattern so that the bench can predict every bit
`timescale 1ns/1ps
module upstream_model (
  input wire logic ref_clk, // Converter clock
  input wire logic clear, // Reset or restart seen by the block
  input wire logic rate_select, // Same rate as the block
  input wire logic frame_clk, // Framing clock from the block
  output ser_pkg::word_t parallel_in // Word offered to the block
);
  int k = 0;
  logic last = 1'b0;
  // Step to the next word one edge after the framing clock reaches the rate's level
  // Clear takes the cleared framing level as the last one, so a restart is no step
  always @(posedge ref_clk) begin
    if (clear) begin
      k = 0;
      last = 1'b0;
    end else if (frame_clk !== last) begin
      if (frame_clk === rate_select) begin
        k = k + 1;
      end
      last = frame_clk;
    end
    parallel_in <= ser_pkg::word_t'(k * 8'h3b + 8'ha5);
  end
endmodule // upstream_model
